//--- src/gst_timer.sv
// Operation
// - compare trigger in auto-conversion mode clears the whole count
// - a trigger clear never raises the rollover flag
// - compare value acts as period, count restarts from zero on match
// - a count byte write in the trigger cycle wins over the clear
// - clock source field picks low_freq_internal_osc, pin/osc, fosc or fosc/4
// - source 10 counts pin edges, or secondary oscillator when selected
// - prescale field divides selected clock by 1, 2, 4 or 8
// - sync_disable low synchronises external sources, ignored for 0x
// - timer_on enables counting; off stops and clears toggle flip-flop
// - gate_enable lets gate control counting only while timer is on
// - gate_polarity high counts on high gate, low counts on low
// - toggle mode routes gate through toggle flop; off clears it
// - single pulse mode bit places gate under single pulse control
// - acquire status is one while armed; cleared when done or mode off
// - gate value bit shows gate level sampled at first phase
// - gate source field picks pin, counter-zero wrap, cmp1 or cmp2
// - count readable and writable as separate low and high bytes
// - writable control bits reset to zero
// - count rolls from maximum to zero and flags rollover
// - falling edge of gate value bit raises gate event flag
// - armed single pulse counts from next active edge to trailing edge
// - counter-zero wrap pulse feeds the gate as source 01
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gst_timer (
    input  wire logic        clk,             // system clock, 40 MHz
    input  wire logic        resetn,          // async reset, active low
    input  wire logic        ce,              // clock enable, freezes state
    input  wire logic        hsel,            // slave select
    input  wire logic [31:0] haddr,           // byte address
    input  wire logic [1:0]  htrans,          // transfer type
    input  wire logic        hwrite,          // write not read
    input  wire logic [2:0]  hsize,           // transfer size, word only
    input  wire logic [31:0] hwdata,          // write data
    input  wire logic        hready,          // bus ready
    output logic      [31:0] hrdata,          // read data
    output logic             hreadyout,       // slave ready
    output logic             hresp,           // always okay
    input  wire logic        low_freq_internal_osc_in,     // low_freq_internal_osc level
    input  wire logic        clock_pin_in,    // remapped_clock_pin level
    input  wire logic        secondary_oscillator_in,         // secondary_oscillator level
    input  wire logic        gate_pin_in,     // gate pin level
    input  wire logic        t0_wrap_in,      // counter_zero_timer wrap pulse
    input  wire logic        cmp1_in,         // comparator 1 output
    input  wire logic        cmp2_in,         // comparator 2 output
    input  wire logic        act_enable,      // compare unit in trigger mode
    input  wire logic [15:0] compare_value,   // compare_value_high:low
    output logic      [15:0] count_value,     // time base for compare unit
    output logic             rollover_flag,   // pulse on rollover
    output logic             gate_event_flag, // pulse on gate value fall
    output logic             act_clear,       // pulse on trigger clear
    output logic             gate_value       // gate_value_status copy
);
    typedef struct packed {
        logic [7:0]        tcon;
        logic [7:0]        gcon;
        logic [15:0]       cnt;
        logic [1:0]        phase;
        logic [2:0]        presc;
        logic              sync_a;
        logic              sync_b;
        logic              src_prev;
        logic              tff;
        logic              g_prev;
        logic              gt_prev;
        logic              sp_run;
        gst_pkg::gst_bus_t bus;
        logic [7:0]        addr;
        logic              wr_pend;
        logic [31:0]       rdata;
        logic              ready;
        logic              resp;
        logic              roll;
        logic              gevt;
        logic              actclr;
    } gst_state_t;

    localparam gst_state_t STATE_RST = '{
        tcon: gst_pkg::TIMER_CTRL_RST, gcon: gst_pkg::GATE_CTRL_RST,
        cnt: gst_pkg::COUNT_RST, phase: gst_pkg::PHASE_Q1,
        presc: 3'h0, sync_a: 1'b0, sync_b: 1'b0, src_prev: 1'b0,
        tff: 1'b0, g_prev: 1'b0, gt_prev: 1'b0, sp_run: 1'b0,
        bus: gst_pkg::GST_BUS_IDLE, addr: 8'h00, wr_pend: 1'b0,
        rdata: 32'h0000_0000, ready: 1'b1, resp: 1'b0,
        roll: 1'b0, gevt: 1'b0, actclr: 1'b0};

    gst_state_t s;
    gst_state_t n;

    logic [1:0]  cs;
    logic [1:0]  ps;
    logic [1:0]  gss;
    logic        on;
    logic        ext_raw;
    logic        ext_lvl;
    logic        src_tick;
    logic [2:0]  mask;
    logic        presc_tick;
    logic        gsrc;
    logic        g;
    logic        gt;
    logic        gt_rise;
    logic        gt_fall;
    logic        gate_lvl;
    logic        count_en;
    logic        inc;
    logic        act_fire;
    logic        accept;
    logic        cnt_wr;
    logic [31:0] rmux;

    // next-state logic for the whole block
    always_comb begin
        n = s;
        n.roll = 1'b0;
        n.gevt = 1'b0;
        n.actclr = 1'b0;
        cs = s.tcon[gst_pkg::TC_CS_HI:gst_pkg::TC_CS_LO];
        ps = s.tcon[gst_pkg::TC_PS_HI:gst_pkg::TC_PS_LO];
        gss = s.gcon[gst_pkg::GC_GSS_HI:gst_pkg::GC_GSS_LO];
        on = s.tcon[gst_pkg::TC_ON];
        n.phase = s.phase + 2'h1;

        // external source choice; low_freq_internal_osc shares the 1x sync path
        if (cs == gst_pkg::CS_LOW_FREQ_INTERNAL_OSC) begin
            ext_raw = low_freq_internal_osc_in;
        end else if (s.tcon[gst_pkg::TC_SECONDARY_OSCILLATOR]) begin
            ext_raw = secondary_oscillator_in;
        end else begin
            ext_raw = clock_pin_in;
        end
        n.sync_a = ext_raw;
        n.sync_b = s.sync_a;
        // unsynchronised path trades two cycles of latency for missed edges
        ext_lvl = s.tcon[gst_pkg::TC_SYNCDIS] ? ext_raw : s.sync_b;
        n.src_prev = ext_lvl;
        unique case (cs)
            gst_pkg::CS_FOSC4: src_tick = (s.phase == gst_pkg::PHASE_LAST);
            gst_pkg::CS_FOSC:  src_tick = 1'b1;
            gst_pkg::CS_PIN_OSC,
            gst_pkg::CS_LOW_FREQ_INTERNAL_OSC: src_tick = ext_lvl & ~s.src_prev;
        endcase

        // prescaler, held in reset while the timer is off
        unique case (ps)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
        endcase
        presc_tick = src_tick & ((s.presc & mask) == mask);
        if (!on) begin
            n.presc = 3'h0;
        end else if (presc_tick) begin
            n.presc = 3'h0;
        end else if (src_tick) begin
            n.presc = s.presc + 3'h1;
        end

        // gate source and polarity
        unique case (gss)
            gst_pkg::GSS_PIN:  gsrc = gate_pin_in;
            gst_pkg::GSS_T0:   gsrc = t0_wrap_in;
            gst_pkg::GSS_CMP1: gsrc = cmp1_in;
            gst_pkg::GSS_CMP2: gsrc = cmp2_in;
        endcase
        g = s.gcon[gst_pkg::GC_POL] ? gsrc : ~gsrc;
        n.g_prev = g;
        if (!s.gcon[gst_pkg::GC_TM] || !on) begin
            n.tff = 1'b0;
        end else if (g & ~s.g_prev) begin
            n.tff = ~s.tff;
        end
        gt = s.gcon[gst_pkg::GC_TM] ? s.tff : g;
        n.gt_prev = gt;
        gt_rise = gt & ~s.gt_prev;
        gt_fall = ~gt & s.gt_prev;

        // single pulse: armed, runs one active phase, then disarms
        if (!s.gcon[gst_pkg::GC_SPM]) begin
            n.sp_run = 1'b0;
            n.gcon[gst_pkg::GC_GO] = 1'b0;
        end else if (s.sp_run && gt_fall) begin
            n.sp_run = 1'b0;
            n.gcon[gst_pkg::GC_GO] = 1'b0;
        end else if (s.gcon[gst_pkg::GC_GO] && !s.sp_run && gt_rise) begin
            n.sp_run = 1'b1;
        end
        gate_lvl = s.gcon[gst_pkg::GC_SPM] ? (s.sp_run & gt) : gt;

        // gate value sampled once per instruction cycle
        if (s.phase == gst_pkg::PHASE_Q1) begin
            n.gcon[gst_pkg::GC_GVAL] = gate_lvl;
            n.gevt = s.gcon[gst_pkg::GC_GVAL] & ~gate_lvl;
        end

        // counting and trigger clear
        count_en = on & (~s.gcon[gst_pkg::GC_GE] | gate_lvl);
        inc = presc_tick & count_en;
        act_fire = act_enable & inc & (s.cnt == compare_value);
        if (act_fire) begin
            n.cnt = gst_pkg::COUNT_RST;
            n.actclr = 1'b1;
        end else if (inc) begin
            n.cnt = s.cnt + 16'h0001;
            n.roll = (s.cnt == gst_pkg::COUNT_MAX);
        end

        // bus data phase of a write
        cnt_wr = 1'b0;
        if (s.wr_pend) begin
            unique case (s.addr)
                gst_pkg::ADDR_TIMER_CTRL: begin
                    n.tcon = hwdata[7:0] & gst_pkg::TC_WMASK;
                end
                gst_pkg::ADDR_GATE_CTRL: begin
                    n.gcon = (hwdata[7:0] & gst_pkg::GC_WMASK)
                           | (n.gcon & ~gst_pkg::GC_WMASK);
                    // arming only sticks while single pulse mode is on
                    n.gcon[gst_pkg::GC_GO] = hwdata[gst_pkg::GC_GO]
                                           & hwdata[gst_pkg::GC_SPM];
                end
                gst_pkg::ADDR_COUNT_LOW: begin
                    n.cnt = {s.cnt[15:8], hwdata[7:0]};
                    cnt_wr = 1'b1;
                end
                gst_pkg::ADDR_COUNT_HIGH: begin
                    n.cnt = {hwdata[7:0], s.cnt[7:0]};
                    cnt_wr = 1'b1;
                end
                default: begin
                end
            endcase
        end
        if (cnt_wr) begin
            n.actclr = 1'b0;
            n.roll = 1'b0;
        end

        // read mux; unmapped offsets read as zero
        unique case (s.addr)
            gst_pkg::ADDR_TIMER_CTRL: rmux = {24'h000000, s.tcon};
            gst_pkg::ADDR_GATE_CTRL:  rmux = {24'h000000, s.gcon};
            gst_pkg::ADDR_COUNT_LOW:  rmux = {24'h000000, s.cnt[7:0]};
            gst_pkg::ADDR_COUNT_HIGH: rmux = {24'h000000, s.cnt[15:8]};
            default:                  rmux = 32'h0000_0000;
        endcase

        // bus address phase; reads wait one cycle so a write just before
        // has landed before the value is picked
        n.wr_pend = 1'b0;
        n.resp = 1'b0;
        accept = hsel & htrans[1] & hready;
        unique case (s.bus)
            gst_pkg::GST_BUS_IDLE: begin
                if (accept) begin
                    n.addr = haddr[gst_pkg::ADDR_W-1:0];
                    if (hwrite) begin
                        n.wr_pend = 1'b1;
                    end else begin
                        n.bus = gst_pkg::GST_BUS_RDWAIT;
                        n.ready = 1'b0;
                    end
                end
            end
            gst_pkg::GST_BUS_RDWAIT: begin
                n.rdata = rmux;
                n.ready = 1'b1;
                n.bus = gst_pkg::GST_BUS_IDLE;
            end
            default: begin
                n.bus = gst_pkg::GST_BUS_IDLE;
                n.ready = 1'b1;
            end
        endcase
    end

    // single state register, frozen while ce is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= STATE_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    // outputs come straight from the state register
    assign hrdata          = s.rdata;
    assign hreadyout       = s.ready;
    assign hresp           = s.resp;
    assign count_value     = s.cnt;
    assign rollover_flag   = s.roll;
    assign gate_event_flag = s.gevt;
    assign act_clear       = s.actclr;
    assign gate_value      = s.gcon[gst_pkg::GC_GVAL];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence sq_sp_end;
        ce && s.sp_run && gt_fall && s.gcon[gst_pkg::GC_SPM] && !s.wr_pend;
    endsequence
    sequence sq_sp_done;
        !s.sp_run && !s.gcon[gst_pkg::GC_GO];
    endsequence

    a_roll_at_max: assert property (
        ce && inc && !act_fire && !cnt_wr && s.cnt == gst_pkg::COUNT_MAX
        |=> s.roll && s.cnt == gst_pkg::COUNT_RST)
        else $error("rollover not flagged at maximum count");
    a_act_no_roll: assert property (
        s.actclr |-> !s.roll)
        else $error("trigger clear raised rollover");
    a_act_clears: assert property (
        ce && act_fire && !cnt_wr |=> s.actclr && s.cnt == 16'h0000)
        else $error("trigger did not clear the count");
    a_write_wins: assert property (
        ce && act_fire && cnt_wr |=> !s.actclr)
        else $error("trigger clear beat a count write");
    a_off_clears_tff: assert property (
        ce && !on |=> !s.tff && s.presc == 3'h0)
        else $error("timer off left toggle flop or prescaler set");
    a_tm_off_tff: assert property (
        ce && !s.gcon[gst_pkg::GC_TM] |=> !s.tff)
        else $error("toggle flop not held clear");
    a_go_clear_spm: assert property (
        ce && !s.gcon[gst_pkg::GC_SPM] && !s.wr_pend
        |=> !s.gcon[gst_pkg::GC_GO] && !s.sp_run)
        else $error("acquire status kept without single pulse mode");
    a_sp_trailing: assert property (
        sq_sp_end |=> sq_sp_done)
        else $error("single pulse not ended at trailing edge");
    a_gval_q1_only: assert property (
        ce && s.phase != gst_pkg::PHASE_Q1
        |=> $stable(s.gcon[gst_pkg::GC_GVAL]))
        else $error("gate value changed outside first phase");
    a_gevt_on_fall: assert property (
        $fell(s.gcon[gst_pkg::GC_GVAL]) |-> s.gevt)
        else $error("gate value fall without gate event");
    a_fosc_counts: assert property (
        ce && on && cs == gst_pkg::CS_FOSC && ps == 2'h0
        && !s.gcon[gst_pkg::GC_GE] && !act_fire && !cnt_wr
        |=> s.cnt == 16'($past(s.cnt) + 16'h0001))
        else $error("system clock source did not count every cycle");
    a_presc_div8: assert property (
        ce && on && src_tick && ps == 2'h3 && s.presc != 3'h7
        |-> !presc_tick)
        else $error("divide by eight ticked early");
endmodule
`default_nettype wire

//--- src/gst_pkg.sv
// shared constants for the gated sixteen bit timer
package gst_pkg;
    // register byte offsets inside the slave window
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GATE_CTRL  = 8'h04;
    localparam logic [7:0] ADDR_COUNT_LOW  = 8'h08;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0c;
    localparam int         ADDR_W          = 8;

    // timer_control field positions
    localparam int TC_CS_HI   = 7;
    localparam int TC_CS_LO   = 6;
    localparam int TC_PS_HI   = 5;
    localparam int TC_PS_LO   = 4;
    localparam int TC_SECONDARY_OSCILLATOR    = 3;
    localparam int TC_SYNCDIS = 2;
    localparam int TC_ON      = 0;
    localparam logic [7:0] TC_WMASK = 8'hfd;

    // gate_control field positions
    localparam int GC_GE     = 7;
    localparam int GC_POL    = 6;
    localparam int GC_TM     = 5;
    localparam int GC_SPM    = 4;
    localparam int GC_GO     = 3;
    localparam int GC_GVAL   = 2;
    localparam int GC_GSS_HI = 1;
    localparam int GC_GSS_LO = 0;
    localparam logic [7:0] GC_WMASK = 8'hf3;

    // reset values and maximum count
    localparam logic [7:0]  TIMER_CTRL_RST = 8'h00;
    localparam logic [7:0]  GATE_CTRL_RST  = 8'h00;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hffff;

    // clock source codes
    localparam logic [1:0] CS_LOW_FREQ_INTERNAL_OSC = 2'h3;
    localparam logic [1:0] CS_PIN_OSC  = 2'h2;
    localparam logic [1:0] CS_FOSC     = 2'h1;
    localparam logic [1:0] CS_FOSC4    = 2'h0;

    // gate source codes
    localparam logic [1:0] GSS_PIN  = 2'h0;
    localparam logic [1:0] GSS_T0   = 2'h1;
    localparam logic [1:0] GSS_CMP1 = 2'h2;
    localparam logic [1:0] GSS_CMP2 = 2'h3;

    // instruction cycle phases of the system clock divided by four
    localparam logic [1:0] PHASE_Q1   = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        GST_BUS_IDLE   = 2'b01,
        GST_BUS_RDWAIT = 2'b10
    } gst_bus_t;
endpackage

//--- tb/gst_partner.sv
`timescale 1ns/1ps
`default_nettype none
module gst_partner (
    input  wire logic        clk,           // system clock
    input  wire logic        resetn,        // async reset, active low
    input  wire logic [2:0]  gate_lv,       // pin, cmp1, cmp2 levels wanted
    input  wire logic        act_req,       // compare unit trigger mode
    input  wire logic [15:0] period_req,    // compare value wanted
    output logic             low_freq_internal_osc_in,   // slow oscillator, period 6
    output logic             clock_pin_in,  // pin clock, period 10
    output logic             secondary_oscillator_in,       // secondary osc, period 14
    output logic             gate_pin_in,   // gate pin level
    output logic             t0_wrap_in,    // counter-zero wrap pulse
    output logic             cmp1_in,       // comparator 1 level
    output logic             cmp2_in,       // comparator 2 level
    output logic             act_enable,    // trigger mode to the timer
    output logic [15:0]      compare_value  // period while triggering
);
    logic [7:0] t0_q;
    int         lf_q;
    int         pin_q;
    int         so_q;
    // distinct source periods so a wrong clock mux shows in the count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            t0_q          <= 8'h00;
            lf_q          <= 0;
            pin_q         <= 0;
            so_q          <= 0;
            act_enable    <= 1'b0;
            compare_value <= 16'hffff;
        end else begin
            t0_q          <= t0_q + 8'h01;
            lf_q          <= (lf_q == 5) ? 0 : lf_q + 1;
            pin_q         <= (pin_q == 9) ? 0 : pin_q + 1;
            so_q          <= (so_q == 13) ? 0 : so_q + 1;
            act_enable    <= act_req;
            compare_value <= period_req;
        end
    end
    assign low_freq_internal_osc_in  = (lf_q < 3);
    assign clock_pin_in = (pin_q < 5);
    assign secondary_oscillator_in      = (so_q < 7);
    // one high cycle each time the 8-bit counter wraps to zero
    assign t0_wrap_in   = (t0_q == 8'hff);
    assign gate_pin_in  = gate_lv[0];
    assign cmp1_in      = gate_lv[1];
    // this variant has a second comparator, so source 11 is legal
    assign cmp2_in      = gate_lv[2];
endmodule
`default_nettype wire

//--- tb/gated_sixteen_bit_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module gated_sixteen_bit_timer_test;
    logic clk, resetn, hsel, hwrite, hreadyout, hresp, act_req, ce;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, gate_lv;
    logic [15:0] period_req, compare_value, count_value;
    logic lf, cpin, secondary_oscillator, gpin, t0w, c1, c2, act_en;
    logic roll, gev, actc, gval;
    int   errors, checks_done, n_roll, n_act, n_gev;
    integer seed;
    gst_timer i_gst_timer (.clk(clk), .resetn(resetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_freq_internal_osc_in(lf), .clock_pin_in(cpin), .secondary_oscillator_in(secondary_oscillator),
        .gate_pin_in(gpin), .t0_wrap_in(t0w), .cmp1_in(c1), .cmp2_in(c2),
        .act_enable(act_en), .compare_value(compare_value),
        .count_value(count_value), .rollover_flag(roll),
        .gate_event_flag(gev), .act_clear(actc), .gate_value(gval));
    gst_partner i_gst_partner (.clk(clk), .resetn(resetn),
        .gate_lv(gate_lv), .act_req(act_req), .period_req(period_req),
        .low_freq_internal_osc_in(lf), .clock_pin_in(cpin), .secondary_oscillator_in(secondary_oscillator),
        .gate_pin_in(gpin), .t0_wrap_in(t0w), .cmp1_in(c1), .cmp2_in(c2),
        .act_enable(act_en), .compare_value(compare_value));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // pulse counters; windows are judged by differences, never reset
    always @(posedge clk) begin
        if (roll === 1'b1) n_roll++;
        if (actc === 1'b1) n_act++;
        if (gev === 1'b1) n_gev++;
    end
    task automatic stop_test;
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one single word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
        `CHK(hresp, 1'b0)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(a, 1'b0, 8'h00, r);
    endtask
    task automatic delta(input int n, output logic [15:0] d);
        logic [15:0] a;
        a = count_value;
        tick(n);
        d = count_value - a;
    endtask
    // source clock cycles per tick before the prescaler
    function automatic int src_per(input logic [1:0] cs, input logic s);
        case (cs)
            gst_pkg::CS_FOSC4: return 4;
            gst_pkg::CS_FOSC:  return 1;
            gst_pkg::CS_LOW_FREQ_INTERNAL_OSC: return 6;
            default: return s ? 14 : 10;
        endcase
    endfunction
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        stop_test;
    end
    initial begin
        logic [31:0] r;
        logic [15:0] d, c;
        logic [7:0]  v, h;
        logic [1:0]  g;
        logic        ok, lv;
        int          per, a0;
        seed = 32'h6fbbea72;
        resetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; gate_lv = 3'b001;
        act_req = 1'b0; period_req = 16'hffff; ce = 1'b1;
        errors = 0; checks_done = 0; n_roll = 0; n_act = 0; n_gev = 0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
        // reset values, unmapped place, masked and read-only bits
        rd(gst_pkg::ADDR_TIMER_CTRL, r); `CHK(r, 32'h0)
        rd(gst_pkg::ADDR_GATE_CTRL, r); `CHK(r & 32'hfb, 32'h0)
        rd(8'h10, r); `CHK(r, 32'h0)
        repeat (6) begin
            v = 8'($random(seed));
            wr(gst_pkg::ADDR_TIMER_CTRL, v & 8'hfe);
            rd(gst_pkg::ADDR_TIMER_CTRL, r); `CHK(r, {24'h0, v & 8'hfc})
            wr(gst_pkg::ADDR_GATE_CTRL, v & 8'hf7);
            rd(gst_pkg::ADDR_GATE_CTRL, r); `CHK(r & 32'hfb, {24'h0, v & 8'hf3})
            h = 8'($random(seed));
            wr(gst_pkg::ADDR_COUNT_LOW, v);
            wr(gst_pkg::ADDR_COUNT_HIGH, h);
            rd(gst_pkg::ADDR_COUNT_LOW, r); `CHK(r, {24'h0, v})
            rd(gst_pkg::ADDR_COUNT_HIGH, r); `CHK(r, {24'h0, h})
            `CHK(count_value, {h, v})
        end
        wr(gst_pkg::ADDR_GATE_CTRL, 8'h00);
        // every source and prescale; secondary_oscillator and sync bits ride on ps
        for (int i = 0; i < 16; i++) begin
            per = src_per(i[3:2], i[0]) * (1 << i[1:0]);
            wr(gst_pkg::ADDR_TIMER_CTRL, {i[3:0], i[0], i[1], 2'b01});
            tick(per + 8);
            delta(8 * per, d); `CHK(d, 16'd8)
        end
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h40);
        delta(50, d); `CHK(d, 16'd0)
        // rollover from near the top
        wr(gst_pkg::ADDR_COUNT_LOW, 8'hf0);
        wr(gst_pkg::ADDR_COUNT_HIGH, 8'hff);
        a0 = n_roll;
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h41);
        tick(32); `CHK(n_roll - a0, 1)
        // clock enable low must freeze the running count
        ce <= 1'b0;
        tick(1);
        delta(20, d); `CHK(d, 16'd0)
        ce <= 1'b1;
        tick(1);
        // trigger period, run synchronised from the instruction clock
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h00);
        c = 16'd5 + 16'($random(seed) & 32'h0000_000f);
        period_req <= c;
        act_req <= 1'b1;
        wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h01);
        tick(4 * (c + 1) + 8);
        a0 = n_act;
        per = n_roll;
        ok = 1'b1;
        repeat (24 * (c + 1)) begin
            @(posedge clk);
            if (count_value > c) ok = 1'b0;
        end
        `CHK(n_act - a0, 6)
        `CHK(n_roll - per, 0)
        `CHK(ok, 1'b1)
        // count byte writes racing the clear; odd gaps shift the phase
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h41);
        ok = 1'b1;
        for (int k = 0; k < 4 * (c + 1); k++) begin
            wr(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
            tick(k % 2);
            if (count_value > c) ok = 1'b0;
        end
        `CHK(ok, 1'b1)
        act_req <= 1'b0;
        // gate sources, polarity, active and inactive levels
        for (int i = 0; i < 12; i++) begin
            g = (i % 3 == 0) ? 2'd0 : 2'(i % 3 + 1);
            lv = (i / 6 == 1) ? i[0] : ~i[0];
            gate_lv <= (3'b001 << (i % 3)) & {3{lv}}
                     | ~(3'b001 << (i % 3)) & {3{~lv}};
            wr(gst_pkg::ADDR_GATE_CTRL, {1'b1, i[0], 4'h0, g});
            wr(gst_pkg::ADDR_TIMER_CTRL, 8'h41);
            tick(8);
            delta(16, d); `CHK(d, (i / 6 == 1) ? 16'd16 : 16'd0)
            `CHK(gval, (i / 6 == 1))
        end
        // toggle flop on the counter-zero wrap: high half the time
        wr(gst_pkg::ADDR_GATE_CTRL, 8'he1);
        tick(600);
        delta(1024, d); `CHK(d, 16'd512)
        // gate event while gate control is off
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h00);
        wr(gst_pkg::ADDR_GATE_CTRL, 8'h40);
        gate_lv <= 3'b001;
        tick(12); `CHK(gval, 1'b1)
        a0 = n_gev;
        gate_lv <= 3'b000;
        tick(12); `CHK(n_gev - a0, 1)
        // single pulse: one window only, then no more counting
        wr(gst_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(gst_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(gst_pkg::ADDR_GATE_CTRL, 8'hd8);
        wr(gst_pkg::ADDR_TIMER_CTRL, 8'h41);
        tick(20);
        rd(gst_pkg::ADDR_GATE_CTRL, r); `CHK(r[3], 1'b1)
        `CHK(count_value, 16'h0)
        for (int k = 0; k < 2; k++) begin
            gate_lv <= 3'b001;
            tick(20);
            gate_lv <= 3'b000;
            tick(20);
            if (k == 0) d = count_value;
        end
        `CHK(d >= 16'd16 && d <= 16'd22, 1'b1)
        `CHK(count_value, d)
        rd(gst_pkg::ADDR_GATE_CTRL, r); `CHK(r[3], 1'b0)
        wr(gst_pkg::ADDR_GATE_CTRL, 8'hd8);
        wr(gst_pkg::ADDR_GATE_CTRL, 8'hc0);
        rd(gst_pkg::ADDR_GATE_CTRL, r); `CHK(r[3], 1'b0)
        stop_test;
    end
endmodule
`default_nettype wire
